/* hw/lmpa_arbiter.sv */
// Line multiplexer priority arbiter toward the processor channel
`default_nettype none
`include "lmpa_defs.svh"
module lmpa_arbiter #(
  parameter int NPOS = `LMPA_DEFAULT_POS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Static plugboard setting for the upper index bits
  input wire logic [`LMPA_PLUG_W-1:0] plug_index,
  // Line terminal side: odd positions are input, even positions output
  input wire logic [`LMPA_MAX_POS-1:0] line_terminal_req,
  input wire logic [`LMPA_MAX_POS*`LMPA_DATA_W-1:0] line_terminal_data,
  output logic [`LMPA_MAX_POS-1:0] line_terminal_done,
  // Processor channel side
  output logic input_data_req,
  output logic output_data_req,
  output lmpa_pkg::lmpa_data_t input_data,
  output lmpa_pkg::lmpa_index_t external_index,
  output logic [`LMPA_PAIR_ID_W-1:0] terminal_pair_id,
  input wire logic input_ack,
  input wire logic output_ack
);
  ////////////////////////////////////////////////////////////////////////////
  // reject illegal sizes at elaboration
  if (NPOS != 4 && NPOS != 8 && NPOS != 16 && NPOS != 32 && NPOS != 64) begin : g_bad_size
    $error("lmpa_arbiter: NPOS must be 4, 8, 16, 32 or 64");
  end

  // Position parity tells direction
  function automatic logic is_input_pos(input lmpa_pkg::lmpa_pos_t p);
    is_input_pos = p[0];
  endfunction

  // Pair id: positions 2k and 2k+1 share pair k
  function automatic logic [`LMPA_PAIR_ID_W-1:0] pair_of(input lmpa_pkg::lmpa_pos_t p);
    pair_of = {2'h0, p[`LMPA_POS_W-1:1]};
  endfunction

  // External index: plugboard bits above the position code
  function automatic lmpa_pkg::lmpa_index_t index_of(input logic [`LMPA_PLUG_W-1:0] plug,
    input lmpa_pkg::lmpa_pos_t p);
    index_of = {plug, p};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pending mask, limited to built positions
  logic [`LMPA_MAX_POS-1:0] size_mask;
  logic [`LMPA_MAX_POS-1:0] pending;
  logic found;
  lmpa_pkg::lmpa_pos_t winner;

  // positions above size are absent, half odd half even
  always_comb begin
    size_mask = '0;
    for (int i = 0; i < NPOS; i++) begin
      size_mask[i] = 1'b1;
    end
  end

  // only live terminal requests are considered
  assign pending = line_terminal_req & size_mask;

  lmpa_pick #(.NPOS(NPOS)) i_lmpa_pick (
    .pending(pending),
    .found(found),
    .winner(winner)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Grant state
  lmpa_pkg::lmpa_state_e state;
  lmpa_pkg::lmpa_state_e next_state;
  lmpa_pkg::lmpa_pos_t grant_pos;
  lmpa_pkg::lmpa_pos_t next_grant_pos;
  logic next_input_data_req;
  logic next_output_data_req;
  lmpa_pkg::lmpa_data_t next_input_data;
  lmpa_pkg::lmpa_index_t next_external_index;
  logic [`LMPA_PAIR_ID_W-1:0] next_terminal_pair_id;
  logic [`LMPA_MAX_POS-1:0] next_line_terminal_done;
  logic ack_hit;
  logic take_grant;
  logic take_ack;

  // Acknowledge must match the direction of the current grant
  // input ack ends an input transfer
  // output ack ends an output transfer
  assign ack_hit = is_input_pos(grant_pos) ? input_ack : output_ack;

  // Strobes shared by the three state groups
  // grants are taken only from idle
  assign take_grant = (state == lmpa_pkg::LMPA_IDLE) && found;
  // only the matching acknowledge ends a grant
  assign take_ack = (state == lmpa_pkg::LMPA_GRANT) && ack_hit;

  // Next state and granted position
  always_comb begin
    next_state = state;
    next_grant_pos = grant_pos;
    unique case (state)
      lmpa_pkg::LMPA_IDLE: begin
        // fresh evaluation every time the machine is idle
        if (take_grant) begin
          next_state = lmpa_pkg::LMPA_GRANT;
          next_grant_pos = winner;
        end
      end
      lmpa_pkg::LMPA_GRANT: begin
        // hold the grant until the matching acknowledge
        if (take_ack) begin
          next_state = lmpa_pkg::LMPA_RELEASE;
        end
      end
      lmpa_pkg::LMPA_RELEASE: begin
        // One spare cycle lets the terminal drop its request
        next_state = lmpa_pkg::LMPA_IDLE;
      end
      default: begin
        // Corrupted code falls back to idle
        next_state = lmpa_pkg::LMPA_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state <= lmpa_pkg::LMPA_IDLE;
      grant_pos <= '0;
    end else begin
      state <= next_state;
      grant_pos <= next_grant_pos;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel outputs, captured once at the grant
  // Data is latched so a terminal refilling its buffer cannot disturb it
  always_comb begin
    next_input_data_req = input_data_req;
    next_output_data_req = output_data_req;
    next_input_data = input_data;
    next_external_index = external_index;
    next_terminal_pair_id = terminal_pair_id;
    if (take_grant) begin
      // index goes out with every request
      // every position gives its own code
      // low bits are the position code
      next_external_index = index_of(plug_index, winner);
      // pair id of the granted position
      next_terminal_pair_id = pair_of(winner);
      if (is_input_pos(winner)) begin
        next_input_data = line_terminal_data[winner*`LMPA_DATA_W +: `LMPA_DATA_W];
        next_input_data_req = 1'b1;
      end else begin
        next_output_data_req = 1'b1;
      end
    end else if (take_ack || state != lmpa_pkg::LMPA_GRANT) begin
      // request falls at the acknowledge, index and data stay
      next_input_data_req = 1'b0;
      next_output_data_req = 1'b0;
    end
  end

  // Channel output registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      input_data_req <= 1'b0;
      output_data_req <= 1'b0;
      input_data <= '0;
      external_index <= '0;
      terminal_pair_id <= '0;
    end else begin
      input_data_req <= next_input_data_req;
      output_data_req <= next_output_data_req;
      input_data <= next_input_data;
      external_index <= next_external_index;
      terminal_pair_id <= next_terminal_pair_id;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Done pulse: one cycle on the granted bit, terminal clears its request
  always_comb begin
    next_line_terminal_done = '0;
    if (take_ack) begin
      next_line_terminal_done[grant_pos] = 1'b1;
    end
  end

  // Done pulse register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      line_terminal_done <= '0;
    end else begin
      line_terminal_done <= next_line_terminal_done;
    end
  end
endmodule
`default_nettype wire

/* hw/lmpa_defs.svh */
// Constants for the line multiplexer priority arbiter
`ifndef LMPA_DEFS_SVH
`define LMPA_DEFS_SVH
`define LMPA_MAX_POS 64
`define LMPA_POS_W 6
`define LMPA_PLUG_W 9
`define LMPA_INDEX_W 15
`define LMPA_DATA_W 8
`define LMPA_PAIR_ID_W 7
`define LMPA_DEFAULT_POS 64
`endif

/* hw/lmpa_pick.sv */
// Highest-numbered pending position finder
`default_nettype none
`include "lmpa_defs.svh"
module lmpa_pick #(
  parameter int NPOS = `LMPA_DEFAULT_POS
) (
  // Pending requests, one per position
  input wire logic [`LMPA_MAX_POS-1:0] pending,
  // Winner
  output logic found,
  output lmpa_pkg::lmpa_pos_t winner
);
  // Scan low to high so the highest set position is kept last
  always_comb begin
    found = 1'b0;
    winner = '0;
    for (int i = 0; i < NPOS; i++) begin
      if (pending[i]) begin
        found = 1'b1;
        winner = lmpa_pkg::lmpa_pos_t'(i);
      end
    end
  end
endmodule
`default_nettype wire

/* hw/lmpa_pkg.sv */
// Types shared by the line multiplexer priority arbiter
`default_nettype none
`include "lmpa_defs.svh"
package lmpa_pkg;
  typedef logic [`LMPA_POS_W-1:0] lmpa_pos_t;
  typedef logic [`LMPA_INDEX_W-1:0] lmpa_index_t;
  typedef logic [`LMPA_DATA_W-1:0] lmpa_data_t;
  typedef enum logic [2:0] {
    LMPA_IDLE = 3'h1,
    LMPA_GRANT = 3'h2,
    LMPA_RELEASE = 3'h4
  } lmpa_state_e;
endpackage
`default_nettype wire

/* test/lmpa_arbiter_checker.sv */
// Port assertions for the priority arbiter
`default_nettype none
module lmpa_arbiter_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Watched ports
  input wire logic [8:0] plug_index,
  input wire logic [63:0] line_terminal_req,
  input wire logic [63:0] line_terminal_done,
  input wire logic input_data_req,
  input wire logic output_data_req,
  input wire logic [14:0] external_index,
  input wire logic [6:0] terminal_pair_id,
  input wire logic input_ack,
  input wire logic output_ack
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Granted and acknowledged views
  wire logic gnt = input_data_req | output_data_req;
  wire logic ackd = (input_data_req & input_ack) | (output_data_req & output_ack);
  a_single_grant: assert property (!(input_data_req && output_data_req))
    else $error("both data requests high");
  a_plug_bits: assert property (gnt |-> external_index[14:6] == plug_index)
    else $error("index upper bits wrong");
  a_input_odd: assert property (input_data_req |-> external_index[0])
    else $error("input grant on even position");
  a_output_even: assert property (output_data_req |-> !external_index[0])
    else $error("output grant on odd position");
  a_pair_map: assert property (gnt |-> terminal_pair_id == {2'h0, external_index[5:1]})
    else $error("pair id mismatch");
  a_grant_cause: assert property (gnt |-> line_terminal_req[external_index[5:0]])
    else $error("grant without request");
  a_hold_grant: assert property (gnt && !ackd |=> gnt && $stable(external_index))
    else $error("grant dropped before acknowledge");
  a_release_done: assert property (ackd |=> !gnt && $onehot(line_terminal_done))
    else $error("no release after acknowledge");
  a_rearb_gap: assert property (ackd |=> !gnt [*2])
    else $error("re-arbitration too early");
  a_highest_win: assert property ($rose(gnt) |-> ($past(line_terminal_req) >> external_index[5:0]) == 64'h1)
    else $error("grant not at highest pending position");
  a_no_cause: assert property (!gnt && line_terminal_req == 64'h0 |=> !gnt)
    else $error("grant raised with no request pending");
endmodule
bind lmpa_arbiter lmpa_arbiter_checker i_lmpa_arbiter_checker (.sys_clk, .rstn, .plug_index,
  .line_terminal_req, .line_terminal_done, .input_data_req, .output_data_req, .external_index,
  .terminal_pair_id, .input_ack, .output_ack);
`default_nettype wire

/* test/lmpa_proc_model.sv */
// Processor channel model that acknowledges data requests
`default_nettype none
module lmpa_proc_model (
  // Clock
  input wire logic sys_clk,
  // Channel handshake
  input wire logic input_data_req,
  input wire logic output_data_req,
  output logic input_ack,
  output logic output_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] stall = 2'h0;
  // one-cycle acknowledge
  // Random stall so both prompt and slow answers occur
  always @(posedge sys_clk) begin
    input_ack <= 1'b0;
    output_ack <= 1'b0;
    if ((input_data_req || output_data_req) && !input_ack && !output_ack) begin
      if (stall == 2'h0) begin
        input_ack <= input_data_req;
        output_ack <= output_data_req;
        stall <= 2'($urandom);
      end else begin
        stall <= stall - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* test/tb_lmpa_arbiter.sv */
// Self-checking bench for the priority arbiter
`default_nettype none
module tb_lmpa_arbiter;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [8:0] plug_index = 9'h000;
  logic [63:0] line_terminal_req = 64'h0;
  logic [511:0] line_terminal_data = 512'h0;
  logic [63:0] line_terminal_done;
  logic input_data_req;
  logic output_data_req;
  logic input_ack;
  logic output_ack;
  lmpa_pkg::lmpa_data_t input_data;
  lmpa_pkg::lmpa_index_t external_index;
  logic [6:0] terminal_pair_id;
  logic [23:0] exp_q[$];
  logic [23:0] note;
  int error_cnt = 0;
  int check_count = 0;
  lmpa_arbiter #(.NPOS(64)) i_lmpa_arbiter (.sys_clk, .rstn, .plug_index, .line_terminal_req,
    .line_terminal_data, .line_terminal_done, .input_data_req, .output_data_req, .input_data,
    .external_index, .terminal_pair_id, .input_ack, .output_ack);
  lmpa_proc_model i_lmpa_proc_model (.sys_clk, .input_data_req, .output_data_req, .input_ack, .output_ack);
  initial forever #20 sys_clk = ~sys_clk;
  task automatic chk(input string what, input logic [14:0] exp, input logic [14:0] seen);
    check_count++;
    if (exp !== seen) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Oldest note against each accepted transfer
  always @(posedge sys_clk) begin
    if ((input_data_req && input_ack) || (output_data_req && output_ack)) begin
      if (exp_q.size() == 0) begin
        error_cnt++;
        $display("unexpected transfer: expected none, seen index %h", external_index);
      end else begin
        note = exp_q.pop_front();
        chk("index", note[23:9], external_index);
        chk("direction", {14'h0, note[8]}, {14'h0, input_data_req});
        chk("output request", {14'h0, ~note[8]}, {14'h0, output_data_req});
        chk("pair id", {8'h00, 2'h0, note[14:10]}, {8'h00, terminal_pair_id});
        if (note[8]) chk("data", {7'h00, note[7:0]}, {7'h00, input_data});
      end
    end
  end
  // All requests raised at once; terminals drop theirs on done
  task automatic run_round(input logic [63:0] m);
    for (int b = 0; b < 64; b++) line_terminal_data[8*b +: 8] = 8'($urandom);
    plug_index = 9'($urandom);
    for (int p = 63; p >= 0; p--)
      if (m[p]) exp_q.push_back({plug_index, 6'(p), 1'(p % 2), line_terminal_data[8*p +: 8]});
    line_terminal_req = m;
    for (int c = 0; c < 700 && line_terminal_req != 64'h0; c++) begin
      @(negedge sys_clk);
      line_terminal_req = line_terminal_req & ~line_terminal_done;
    end
    repeat (4) @(negedge sys_clk);
    chk("notes left", 15'h0, 15'(exp_q.size()));
    $display("round done, mask %h", m);
  endtask
  initial begin
    void'($urandom(2));
    repeat (8) @(negedge sys_clk);
    rstn = 1'b1;
    run_round(64'h0000_0000_0000_0020);
    run_round(64'h8000_0000_0000_0001);
    run_round(64'hFFFF_FFFF_FFFF_FFFF);
    repeat (5) run_round({$urandom, $urandom});
    end_of_test;
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    end_of_test;
  end
endmodule
`default_nettype wire
